// ===== pfc_fault_limit.sv
/*
  pfc_fault_limit: consecutive-cycle fault latching, per-cycle limit shutdown with
  blanking, position capture, and output gating after the edge generator.
  assumes cycle_start, period_count, pwm_raw, pwm_enable and burst_off come from
  pwm logic on clk; fault_raw and cycle_limit_signal come from comparators (async).
*/
// Behaviour
// R1 - latch off after count plus one faulted cycles
// R2 - each fault counter is seven bits
// R3 - maximum effective count is 128 cycles
// R4 - latched fault holds until disable then enable
// R5 - limit signal blanks rest of current cycle
// R6 - limit ignored inside blanking windows a, b
// R7 - limit signal also feeds counted latching fault
// R8 - blank mode set: blanking masks latching counter
// R9 - blank mode clear: latching counter sees raw
// R10 - fault or burst gates all four lines
// R11 - capture period count when limit acts
// R12 - captured position is in 4 ns counts
// R13 - fault-free cycle clears that fault counter
// R14 - disabling clears latches and counters
module pfc_fault_limit #(
    parameter int NF = 3
) (
    // clock and reset
    input  wire logic                                          clk,
    input  wire logic                                          rst,
    // pwm timing
    input  wire logic                                          pwm_enable,
    input  wire logic                                          cycle_start,
    input  wire logic [pfc_pkg::PFC_PERIOD_W-1:0]              period_count,
    input  wire logic [pfc_pkg::PFC_LANES-1:0]                 pwm_raw,
    input  wire logic                                          burst_off,
    // comparator inputs
    input  wire logic [NF-1:0]                                 fault_raw,
    input  wire logic                                          cycle_limit_signal,
    // configuration
    input  wire logic [NF-1:0][pfc_pkg::PFC_CNT_W-1:0]         fault_count_limit,
    input  wire logic [pfc_pkg::PFC_CNT_W-1:0]                 cycle_fault_limit,
    input  wire logic                                          cycle_fault_blank_mode,
    input  wire pfc_pkg::pfc_blank_type                        blank_cfg,
    // outputs
    output logic      [pfc_pkg::PFC_LANES-1:0]                 pwm_out,
    output logic      [NF:0]                                   fault_latched,
    output logic                                               cycle_limit_active,
    output logic      [pfc_pkg::PFC_PERIOD_W-1:0]              cycle_limit_position
);

    localparam int NE = NF + 1;

    typedef struct packed {
        logic [NF:0]                                 sync1;
        logic [NF:0]                                 sync2;
        logic [NE-1:0]                               seen;
        logic [NE-1:0][pfc_pkg::PFC_CNT_W-1:0]       cnt;
        logic [NE-1:0]                               latched;
        logic                                        cbc_off;
        logic [pfc_pkg::PFC_PERIOD_W-1:0]            pos;
        logic [pfc_pkg::PFC_LANES-1:0]               out;
    } pfc_state_type;

    pfc_state_type st_q;
    pfc_state_type st_d;

    logic                                  blank_now;
    logic                                  cbc_sync;
    logic                                  cbc_eff;
    logic [NE-1:0]                         src_now;
    logic [NE-1:0]                         seen_now;
    logic [NE-1:0][pfc_pkg::PFC_CNT_W-1:0] limit;
    logic                                  off_d;

    // limit input sits at the top of the synchroniser vector
    assign cbc_sync  = st_q.sync2[NF];
    assign blank_now = ((period_count >= blank_cfg.a_start) && (period_count < blank_cfg.a_end))
                    || ((period_count >= blank_cfg.b_start) && (period_count < blank_cfg.b_end));
    assign cbc_eff   = cbc_sync && !blank_now; // R6

    // per-entry source: external faults, then the counted limit fault
    genvar gi;
    generate
        for (gi = 0; gi < NE; gi++)
        begin : g_src
            if (gi < NF)
            begin : g_pin
                assign src_now[gi] = st_q.sync2[gi];
                assign limit[gi]   = fault_count_limit[gi];
            end
            else
            begin : g_cbc
                // blanking only reaches the counted fault when asked; R7 R8 R9
                assign src_now[gi] = cycle_fault_blank_mode ? cbc_eff : cbc_sync;
                assign limit[gi]   = cycle_fault_limit;
            end
            assign seen_now[gi] = st_q.seen[gi] || src_now[gi];
        end
    endgenerate

    always_comb
    begin
        st_d       = st_q;
        st_d.sync1 = {cycle_limit_signal, fault_raw};
        st_d.sync2 = st_q.sync1;
        if (!pwm_enable)
        begin
            // a later enable starts fault-free
            st_d.seen    = '0; // R14
            st_d.cnt     = '0; // R14
            st_d.latched = '0; // R14
            st_d.cbc_off = 1'b0;
        end
        else
        begin
            for (int i = 0; i < NE; i++)
            begin
                if (cycle_start)
                begin
                    st_d.seen[i] = 1'b0;
                    if (!seen_now[i])
                    begin
                        st_d.cnt[i] = pfc_pkg::PFC_CNT_RST; // R13
                    end
                    else if (st_q.cnt[i] == limit[i])
                    begin
                        // cnt holds prior faulted cycles, so limit 127 gives 128; R1 R2 R3
                        st_d.latched[i] = 1'b1; // R1
                    end
                    else
                    begin
                        st_d.cnt[i] = st_q.cnt[i] + 7'h01;
                    end
                end
                else
                begin
                    st_d.seen[i] = seen_now[i];
                end
            end
            // new limit event wins over the cycle-start release
            st_d.cbc_off = (st_q.cbc_off && !cycle_start) || cbc_eff; // R5
            if (cbc_eff && !st_q.cbc_off)
            begin
                st_d.pos = period_count; // R11 R12
            end
        end
        // gating on next-state terms so the lines drop on the same edge; R4 R10
        off_d    = (|st_d.latched) || st_d.cbc_off || burst_off || !pwm_enable;
        st_d.out = off_d ? pfc_pkg::PFC_OFF : pwm_raw; // R10
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign pwm_out              = st_q.out;
    assign fault_latched        = st_q.latched;
    assign cycle_limit_active   = st_q.cbc_off;
    assign cycle_limit_position = st_q.pos;

    // checks
    property p_latched_gates;
        @(posedge clk) disable iff (rst)
        (|st_q.latched) |-> (pwm_out == 4'h0);
    endproperty
    a_latched_gates: assert property (p_latched_gates) // R10
        else $error("latched fault left a drive line on");

    property p_latch_holds;
        @(posedge clk) disable iff (rst)
        (st_q.latched[0] && pwm_enable) |=> st_q.latched[0];
    endproperty
    a_latch_holds: assert property (p_latch_holds) // R4
        else $error("latched fault released while enabled");

    property p_disable_clears;
        @(posedge clk) disable iff (rst)
        !pwm_enable |=> (st_q.latched == '0) && (st_q.cnt == '0) && (pwm_out == 4'h0);
    endproperty
    a_disable_clears: assert property (p_disable_clears) // R14
        else $error("disable did not clear fault state");

    property p_cbc_release;
        @(posedge clk) disable iff (rst)
        (st_q.cbc_off && cycle_start && !cbc_eff && pwm_enable) |=> !st_q.cbc_off;
    endproperty
    a_cbc_release: assert property (p_cbc_release) // R5
        else $error("cycle limit did not release at cycle start");

    property p_blank_ignores;
        @(posedge clk) disable iff (rst)
        (!st_q.cbc_off && blank_now) |=> !st_q.cbc_off;
    endproperty
    a_blank_ignores: assert property (p_blank_ignores) // R6
        else $error("cycle limit acted inside blanking");

    property p_pos_capture;
        @(posedge clk) disable iff (rst)
        (pwm_enable && cbc_eff && !st_q.cbc_off) |=> (cycle_limit_position == $past(period_count));
    endproperty
    a_pos_capture: assert property (p_pos_capture) // R11
        else $error("position not captured on cycle limit");

    property p_clean_cycle_zero;
        @(posedge clk) disable iff (rst)
        (pwm_enable && cycle_start && !seen_now[0]) |=> (st_q.cnt[0] == 7'h00);
    endproperty
    a_clean_cycle_zero: assert property (p_clean_cycle_zero) // R13
        else $error("fault-free cycle did not clear counter");

    property p_count_latch;
        @(posedge clk) disable iff (rst)
        (pwm_enable && cycle_start && seen_now[0] && (st_q.cnt[0] == limit[0]))
            |=> st_q.latched[0] ##0 (pwm_out == 4'h0);
    endproperty
    a_count_latch: assert property (p_count_latch) // R1
        else $error("fault did not latch at count plus one");

    property p_no_early_latch;
        @(posedge clk) disable iff (rst)
        (pwm_enable && cycle_start && !st_q.latched[0] && (st_q.cnt[0] != limit[0]))
            |=> !st_q.latched[0];
    endproperty
    a_no_early_latch: assert property (p_no_early_latch) // R1
        else $error("fault latched before count reached");

    property p_raw_counts;
        @(posedge clk) disable iff (rst)
        (!cycle_fault_blank_mode && cbc_sync && pwm_enable && !cycle_start) |=> st_q.seen[NF];
    endproperty
    a_raw_counts: assert property (p_raw_counts) // R9
        else $error("unblanked limit not seen by counted fault");

    c_latch: cover property (@(posedge clk) disable iff (rst) $rose(st_q.latched[0]));
    c_cbc: cover property (@(posedge clk) disable iff (rst) $rose(st_q.cbc_off));
    c_cbc_latch: cover property (@(posedge clk) disable iff (rst) $rose(st_q.latched[NF]));
    c_burst: cover property (@(posedge clk) disable iff (rst) burst_off && pwm_raw != 4'h0);

endmodule // pfc_fault_limit

// ===== pfc_pkg.sv
/*
  pfc_pkg: constants and carrier types for the pwm fault and cycle limit logic.
  assumes one 100 MHz pwm clock; the period counter runs in coarse 4 ns counts.
*/
package pfc_pkg;

    // counter geometry
    localparam int PFC_CNT_W      = 7;
    localparam int PFC_MAX_CYCLES = 128;
    localparam int PFC_PERIOD_W   = 14;
    localparam int PFC_LANES      = 4;

    // timing: clock period and coarse period-counter resolution
    localparam int PFC_CLK_NS     = 10;
    localparam int PFC_COARSE_NS  = 4;

    // reset values
    localparam logic [PFC_CNT_W-1:0]    PFC_CNT_RST = 7'h00;
    localparam logic [PFC_PERIOD_W-1:0] PFC_POS_RST = 14'h0000;
    localparam logic [PFC_LANES-1:0]    PFC_OFF     = 4'h0;

    // two blanking windows, each [start, end) in period-counter units
    typedef struct packed {
        logic [PFC_PERIOD_W-1:0] a_start;
        logic [PFC_PERIOD_W-1:0] a_end;
        logic [PFC_PERIOD_W-1:0] b_start;
        logic [PFC_PERIOD_W-1:0] b_end;
    } pfc_blank_type;

endpackage

// ===== pfc_stage_model.sv
/*
  pfc_stage_model: comparators and switching-cycle timing facing the block.
  assumes the design clk and rst; comparator edges land off the clock edge.
*/
module pfc_stage_model #(
    parameter int PER = 16
) (
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             rst,
    // commands from the bench
    input  wire logic [2:0]                       fault_lvl,
    input  wire logic                             limit_on,
    input  wire logic [pfc_pkg::PFC_PERIOD_W-1:0] limit_at,
    // towards the block
    output logic                                  cycle_start,
    output logic      [pfc_pkg::PFC_PERIOD_W-1:0] period_count,
    output logic      [2:0]                       fault_raw,
    output logic                                  cycle_limit_signal
);
    timeunit 1ns;
    timeprecision 100ps;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            period_count <= '0;
            cycle_start  <= 1'b0;
        end
        else
        begin
            period_count <= (period_count == PER - 1) ? '0 : period_count + 1'b1;
            cycle_start  <= (period_count == PER - 2);
        end
    end

    // analog trips are asynchronous, so they move 2-3 ns after the edge
    always @(posedge clk) #2 cycle_limit_signal = limit_on && period_count == limit_at;
    always @(posedge clk) #3 fault_raw = fault_lvl;
endmodule // pfc_stage_model

// ===== pfc_fault_limit_tb_top.sv
/*
  pfc_fault_limit_tb_top: self-checking bench for the fault and cycle limit logic.
  assumes pfc_pkg, pfc_fault_limit and pfc_stage_model are compiled before it.
*/
module pfc_fault_limit_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NF = 3;
    logic                   clk, rst, pwm_enable, burst_off, limit_on, blank_mode, cyc, act;
    logic [3:0]             pwm_raw, out, lat;
    logic [2:0]             fault_lvl, fault_raw;
    logic [NF-1:0][6:0]     lims;
    logic [6:0]             cyc_lim;
    logic [13:0]            limit_at, pc, pos;
    logic                   lim_sig;
    pfc_pkg::pfc_blank_type blank;
    logic [22:0]            exp_q[$], msk_q[$];
    int                     err_total = 0, samples_checked = 0, seed = 32'hc964, cycles = 0, lv;
    event                   chk;

    pfc_fault_limit #(.NF(NF)) DUT (
        .clk(clk), .rst(rst), .pwm_enable(pwm_enable), .cycle_start(cyc), .period_count(pc),
        .pwm_raw(pwm_raw), .burst_off(burst_off), .fault_raw(fault_raw),
        .cycle_limit_signal(lim_sig), .fault_count_limit(lims), .cycle_fault_limit(cyc_lim),
        .cycle_fault_blank_mode(blank_mode), .blank_cfg(blank), .pwm_out(out),
        .fault_latched(lat), .cycle_limit_active(act), .cycle_limit_position(pos));
    pfc_stage_model #(.PER(16)) stage (
        .clk(clk), .rst(rst), .fault_lvl(fault_lvl), .limit_on(limit_on), .limit_at(limit_at),
        .cycle_start(cyc), .period_count(pc), .fault_raw(fault_raw),
        .cycle_limit_signal(lim_sig));

    always #5 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // hang guard, far above the longest fault count run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic compare_obs(input logic [22:0] e, input logic [22:0] m);
        samples_checked++;
        if (({lat, act, out, pos} & m) !== (e & m))
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, {lat, act, out, pos} & m, e & m);
        end
    endtask

    always @(chk)
        compare_obs(exp_q.pop_front(), msk_q.pop_front());

    task automatic note(input logic [3:0] l, input logic a, input logic [3:0] o,
                        input logic [13:0] p, input logic pm);
        exp_q.push_back({l, a, o, p});
        msk_q.push_back({9'h1ff, {14{pm}}});
        -> chk;
    endtask

    task automatic frames(input int n);
        repeat (n)
        begin
            @(negedge clk);
            while (cyc !== 1'b1) @(negedge clk);
            @(negedge clk);
        end
    endtask

    task automatic at_count(input int c);
        @(negedge clk);
        while (pc !== 14'(c)) @(negedge clk);
    endtask

    task automatic restart();
        @(posedge clk);
        pwm_enable <= 1'b0;
        pwm_raw <= 4'($random(seed)) | 4'h1;
        @(posedge clk) pwm_enable <= 1'b1;
        repeat (2) @(negedge clk);
        note(4'h0, 1'b0, pwm_raw, 14'h0, 1'b0);
    endtask

    initial
    begin
        // reset held from time zero, pwm disabled until the first restart
        {clk, rst, pwm_enable, burst_off, limit_on, blank_mode} = 6'h10;
        {fault_lvl, limit_at, pwm_raw, lims} = '0;
        cyc_lim = 7'h7f;
        blank = '{a_start: 14'h0, a_end: 14'h4, b_start: 14'h8, b_end: 14'ha};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        restart();
        @(posedge clk) burst_off <= 1'b1;
        repeat (2) @(negedge clk);
        note(4'h0, 1'b0, 4'h0, 14'h0, 1'b0);
        @(posedge clk) burst_off <= 1'b0;
        $display("test burst done");
        // boundary counts: random small, zero, and the 128-cycle maximum
        for (int k = 0; k < NF; k++)
        begin
            lv = (k == 0) ? ($random(seed) & 3) : ((k == 1) ? 0 : 127);
            lims[k] <= 7'(lv);
            restart();
            frames(1);
            @(posedge clk) fault_lvl <= 3'(1 << k);
            if (lv > 0)
            begin
                frames(lv);
                note(4'h0, 1'b0, pwm_raw, 14'h0, 1'b0);
            end
            frames(1);
            note(4'(1 << k), 1'b0, 4'h0, 14'h0, 1'b0);
            @(posedge clk) fault_lvl <= 3'h0;
            frames(2);
            note(4'(1 << k), 1'b0, 4'h0, 14'h0, 1'b0);
        end
        $display("test fault count done");
        lims[0] <= 7'h1;
        restart();
        frames(1);
        @(posedge clk) fault_lvl <= 3'h1;
        at_count(8);
        @(posedge clk) fault_lvl <= 3'h0;
        frames(2);
        @(posedge clk) fault_lvl <= 3'h1;
        frames(1);
        note(4'h0, 1'b0, pwm_raw, 14'h0, 1'b0);
        frames(1);
        note(4'h1, 1'b0, 4'h0, 14'h0, 1'b0);
        @(posedge clk) fault_lvl <= 3'h0;
        $display("test fault gap done");
        // limit inside window a, inside window b, then unblanked
        for (int j = 0; j < 3; j++)
        begin
            restart();
            @(posedge clk);
            limit_at <= (j == 0) ? 14'h0 : ((j == 1) ? 14'h6 : 14'h4);
            limit_on <= 1'b1;
            frames(1);
            at_count(limit_at + 3);
            note(4'h0, j == 2, (j == 2) ? 4'h0 : pwm_raw, limit_at + 14'h2, j == 2);
            @(posedge clk) limit_on <= 1'b0;
            frames(1);
            note(4'h0, 1'b0, pwm_raw, limit_at + 14'h2, j == 2);
        end
        $display("test cycle limit done");
        for (int m = 0; m < 2; m++)
        begin
            blank_mode <= 1'(m);
            cyc_lim <= 7'h1;
            limit_at <= 14'h0;
            limit_on <= 1'b1;
            restart();
            frames(3);
            note({m == 0, 3'h0}, 1'b0, (m == 0) ? 4'h0 : pwm_raw, 14'h0, 1'b0);
        end
        $display("test counted limit done");
        tally_and_finish();
    end
endmodule // pfc_fault_limit_tb_top
